// ### src/mid_decoder.sv
// Instruction decoder and four-phase sequencer with an Avalon-MM register slave.

// Function
// (RL1) One word each, three kinds take two
// (RL2) Second word has top four bits set
// (RL3) Lone second word executes as no-op
// (RL4) One cycle; idle cycle on taken test/jump
// (RL5) Two-word instructions take two cycles
// (RL6) Instruction cycle is four oscillator periods
// (RL7) Destination bit: zero accumulator, one file
// (RL8) Access bit: zero access bank, one bank register
// (RL9) Three-bit field selects bit zero to seven
// (RL10) Short file address is eight bits
// (RL11) Moves carry full twelve-bit addresses, no bank
// (RL12) Literal is eight, twelve or twenty bits
// (RL13) Four table pointer modes on table access
// (RL14) Offset relative, or absolute for call/return
// (RL15) Literal load names its indirect pointer
// (RL16) Identification words readable despite code protection
// (RL17) Identification words readable by table read
// (RL18) Fast bit saves/restores shadow copies only
// (RL19) Table pointer is 21 bits into program
module mid_decoder
  import mid_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [15:0] prog_word,
  input wire logic prog_valid,
  input wire logic cond_true,
  output logic prog_taken,
  input wire logic [4:0] avm_address,
  input wire logic avm_read,
  input wire logic avm_write,
  input wire logic [31:0] avm_writedata,
  input wire logic [3:0] avm_byteenable,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  output logic issue_valid,
  output logic issue_idle,
  output logic [3:0] issue_class,
  output logic [15:0] issue_word,
  output logic result_to_file,
  output logic access_bank,
  output logic [11:0] data_addr,
  output logic [2:0] bit_num,
  output logic [11:0] move_src,
  output logic [11:0] move_dst,
  output logic [19:0] literal,
  output logic [1:0] ptr_sel,
  output logic [20:0] prog_target,
  output logic target_abs,
  output logic shadow_save,
  output logic shadow_restore,
  output logic tbl_rd,
  output logic tbl_wr,
  output logic [20:0] tbl_addr
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [1:0] phase_q, next_phase;
  mid_seq_t seq_q, next_seq;
  logic flush_q, next_flush;
  logic taken_q, next_taken;
  logic armed_q, next_armed;
  logic [15:0] first_q, next_first;
  mid_issue_t iss_q, next_iss;
  logic [1:0] ctrl_q, next_ctrl;
  logic [3:0] bank_q, next_bank;
  logic [20:0] tp_q, next_tp;
  logic [2:0] status_q, next_status;
  logic [31:0] count_q, next_count;
  logic wait_q, next_wait;
  logic [31:0] rdata_q, next_rdata;
  logic boundary;
  logic flush_now;
  logic [20:0] tbl_ptr_use;
  logic in_id;
  logic bus_wr;
  logic [31:0] wr_merge;

  mid_fld_if fx ();

  mid_fields u_fields (
    .fx(fx.ext)
  );

  // The first word is held while its partner is fetched, so both halves decode together.
  assign fx.w0 = (seq_q == SQ_SECOND) ? first_q : prog_word;
  assign fx.w1 = prog_word;

  // Every decision is made on the last of the four phases of an instruction cycle.
  assign boundary = ctrl_q[CTRL_RUN_BIT] && (phase_q == PHASE_LAST); // RL6
  // A held true test must not starve the stream, so it only counts right after an issue.
  assign flush_now = (seq_q == SQ_FIRST) && (flush_q || (armed_q && cond_true)); // RL4

  // Pre-increment addresses the next location; all other modes use the pointer as it stands.
  assign tbl_ptr_use = (fx.f.tbl_mode == TM_PRE_INC) ? tp_q + 21'h1 : tp_q; // RL19
  assign in_id = (tbl_ptr_use >= ID_FIRST) && (tbl_ptr_use <= ID_LAST);

  // A write lands on the edge where waitrequest is seen low.
  assign bus_wr = avm_write && !wait_q;
  always_comb begin
    wr_merge = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      wr_merge[i*8 +: 8] = avm_byteenable[i] ? avm_writedata[i*8 +: 8] : 8'h00;
    end
  end

  // ==========================================================================
  // Sequencer and decode issue
  // ==========================================================================
  // Issue outputs are pulses; operand fields are only meaningful while issue_valid is high.
  always_comb begin
    next_phase = (phase_q == PHASE_LAST) ? 2'h0 : phase_q + 2'h1; // RL6
    next_seq = seq_q;
    next_flush = flush_q;
    next_taken = 1'b0;
    next_armed = armed_q;
    next_first = first_q;
    next_iss = '0;
    next_tp = tp_q;
    next_count = count_q;
    next_status = status_q;
    if (boundary) begin
      if (flush_now) begin
        // Taken test or changed program counter: burn one cycle as a no-op.
        next_iss.idle = 1'b1; // RL4
        next_flush = 1'b0;
      end else if (prog_valid) begin
        next_taken = 1'b1;
        unique case (seq_q)
          SQ_FIRST: begin
            if (fx.f.two_word) begin
              next_first = prog_word; // RL1 RL5
              next_seq = SQ_SECOND;
            end else if (fx.f.cls == CL_NOP) begin
              next_iss.valid = 1'b1; // RL3
              next_iss.cls = CL_NOP;
              next_iss.word = prog_word;
              next_count = count_q + 32'h1;
              if (prog_word[15:12] == SECOND_TAG) begin
                next_status[ST_STRAY_BIT] = 1'b1;
              end
            end
          end
          SQ_SECOND: begin
            next_seq = SQ_FIRST;
            if (prog_word[15:12] != SECOND_TAG) begin
              // A broken pair is dropped as a no-op rather than acted on half-decoded.
              next_iss.valid = 1'b1; // RL2
              next_iss.cls = CL_NOP;
              next_iss.word = first_q;
              next_status[ST_BAD2_BIT] = 1'b1;
              next_count = count_q + 32'h1;
            end
          end
        endcase
        if (!(seq_q == SQ_FIRST && (fx.f.two_word || fx.f.cls == CL_NOP)) && !next_iss.valid) begin
          next_iss.valid = 1'b1;
          next_iss.cls = fx.f.cls;
          next_iss.word = fx.w0;
          next_iss.to_file = fx.f.to_file; // RL7
          next_iss.access_bank = !fx.f.bank_reg; // RL8
          next_iss.data_addr = fx.f.bank_reg ? {bank_q, fx.f.file_addr} : {ACCESS_BANK, fx.f.file_addr}; // RL8 RL10
          next_iss.bit_num = fx.f.bit_num; // RL9
          next_iss.move_src = fx.f.move_src; // RL11
          next_iss.move_dst = fx.f.move_dst; // RL11
          next_iss.literal = fx.f.literal; // RL12
          next_iss.ptr_sel = fx.f.ptr_sel; // RL15
          next_iss.target = fx.f.target; // RL14
          next_iss.target_abs = fx.f.target_abs; // RL14
          next_iss.shadow_save = fx.f.shadow_save; // RL18
          next_iss.shadow_restore = fx.f.shadow_restore; // RL18
          next_flush = fx.f.pc_change; // RL4
          next_count = count_q + 32'h1;
          if (fx.f.cls == CL_TABLE_RD || fx.f.cls == CL_TABLE_WR) begin
            next_iss.tbl_addr = tbl_ptr_use; // RL19
            unique case (fx.f.tbl_mode)
              TM_NONE: next_tp = tp_q; // RL13
              TM_POST_INC: next_tp = tp_q + 21'h1; // RL13
              TM_POST_DEC: next_tp = tp_q - 21'h1; // RL13
              TM_PRE_INC: next_tp = tp_q + 21'h1; // RL13
            endcase
            if (fx.f.cls == CL_TABLE_WR) begin
              next_iss.tbl_wr = 1'b1;
            end else if (!ctrl_q[CTRL_PROT_BIT] || in_id) begin
              next_iss.tbl_rd = 1'b1; // RL16 RL17
            end else begin
              next_status[ST_BLOCK_BIT] = 1'b1;
            end
          end
        end
      end
      // Only the boundary that closes an issued instruction may see its test as true.
      next_armed = next_iss.valid; // RL4
    end
    // Software writes the pointer only when no table access moves it on the same edge.
    if (bus_wr && avm_address == REG_TABLE_PTR && next_tp == tp_q) begin
      next_tp = (tp_q & ~{{5{avm_byteenable[2]}}, {8{avm_byteenable[1]}}, {8{avm_byteenable[0]}}}) | wr_merge[20:0];
    end
    // One-to-clear status; a flag raised on the same edge survives the clear.
    if (bus_wr && avm_address == REG_STATUS) begin
      next_status = next_status & ~(wr_merge[2:0] & ~(next_status & ~status_q));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      phase_q <= 2'h0;
      seq_q <= SQ_FIRST;
      flush_q <= 1'b0;
      taken_q <= 1'b0;
      armed_q <= 1'b0;
      first_q <= 16'h0000;
      iss_q <= '0;
      tp_q <= 21'h000000;
      count_q <= 32'h0000_0000;
      status_q <= 3'h0;
    end else if (clk_en) begin
      phase_q <= next_phase;
      seq_q <= next_seq;
      flush_q <= next_flush;
      taken_q <= next_taken;
      armed_q <= next_armed;
      first_q <= next_first;
      iss_q <= next_iss;
      tp_q <= next_tp;
      count_q <= next_count;
      status_q <= next_status;
    end
  end

  // ==========================================================================
  // Avalon-MM slave
  // ==========================================================================
  // Every access costs exactly one wait cycle; read data is captured while waitrequest is high.
  always_comb begin
    next_wait = !((avm_read || avm_write) && wait_q);
    next_rdata = rdata_q;
    next_ctrl = ctrl_q;
    next_bank = bank_q;
    if (avm_read && wait_q) begin
      unique case (avm_address)
        REG_CTRL: next_rdata = {30'h0, ctrl_q};
        REG_BANK: next_rdata = {28'h0, bank_q};
        REG_TABLE_PTR: next_rdata = {11'h0, tp_q};
        REG_STATUS: next_rdata = {29'h0, status_q};
        REG_COUNT: next_rdata = count_q;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    if (bus_wr && avm_byteenable[0]) begin
      if (avm_address == REG_CTRL) begin
        next_ctrl = avm_writedata[1:0];
      end
      if (avm_address == REG_BANK) begin
        next_bank = avm_writedata[3:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RESET;
      bank_q <= 4'h0;
    end else if (clk_en) begin
      wait_q <= next_wait;
      rdata_q <= next_rdata;
      ctrl_q <= next_ctrl;
      bank_q <= next_bank;
    end
  end

  // Outputs are fields of registered state.
  assign prog_taken = taken_q;
  assign avm_readdata = rdata_q;
  assign avm_waitrequest = wait_q;
  assign issue_valid = iss_q.valid;
  assign issue_idle = iss_q.idle;
  assign issue_class = iss_q.cls;
  assign issue_word = iss_q.word;
  assign result_to_file = iss_q.to_file;
  assign access_bank = iss_q.access_bank;
  assign data_addr = iss_q.data_addr;
  assign bit_num = iss_q.bit_num;
  assign move_src = iss_q.move_src;
  assign move_dst = iss_q.move_dst;
  assign literal = iss_q.literal;
  assign ptr_sel = iss_q.ptr_sel;
  assign prog_target = iss_q.target;
  assign target_abs = iss_q.target_abs;
  assign shadow_save = iss_q.shadow_save;
  assign shadow_restore = iss_q.shadow_restore;
  assign tbl_rd = iss_q.tbl_rd;
  assign tbl_wr = iss_q.tbl_wr;
  assign tbl_addr = iss_q.tbl_addr;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // Checks assume the clock enable and run bit stay high while they are in flight.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn || !clk_en || !ctrl_q[CTRL_RUN_BIT]);

  property p_cycle_spacing;
    (issue_valid || issue_idle) |=> !(issue_valid || issue_idle) [*3];
  endproperty
  a_cycle_spacing: assert property (p_cycle_spacing) else $error("issue closer than four periods"); // RL6

  property p_stray_nop;
    boundary && !flush_now && prog_valid && seq_q == SQ_FIRST && prog_word[15:12] == SECOND_TAG
      |=> issue_valid && issue_class == CL_NOP && status_q[ST_STRAY_BIT];
  endproperty
  a_stray_nop: assert property (p_stray_nop) else $error("lone second word not a no-op"); // RL3

  property p_two_word_wait;
    boundary && !flush_now && prog_valid && seq_q == SQ_FIRST && fx.f.two_word
      |=> !issue_valid && seq_q == SQ_SECOND && prog_taken;
  endproperty
  a_two_word_wait: assert property (p_two_word_wait) else $error("first word issued alone"); // RL5

  property p_second_tag;
    issue_valid && (issue_class == CL_MOVE || issue_class == CL_LOAD_PTR || issue_class == CL_LONG_XFER)
      |-> $past(prog_word[15:12]) == SECOND_TAG;
  endproperty
  a_second_tag: assert property (p_second_tag) else $error("pair issued without tagged second word"); // RL2

  property p_flush_idle;
    issue_valid && flush_q |-> ##4 issue_idle && !issue_valid;
  endproperty
  a_flush_idle: assert property (p_flush_idle) else $error("no idle cycle after program counter change"); // RL4

  property p_dest;
    issue_valid && issue_class == CL_BYTE |-> result_to_file == issue_word[9] && data_addr[7:0] == issue_word[7:0];
  endproperty
  a_dest: assert property (p_dest) else $error("destination or file address wrong"); // RL7

  property p_bank;
    issue_valid && issue_class == CL_BYTE
      |-> data_addr[11:8] == (issue_word[8] ? $past(bank_q) : ACCESS_BANK);
  endproperty
  a_bank: assert property (p_bank) else $error("bank selection wrong"); // RL8

  property p_post_inc;
    tbl_rd && issue_word[1:0] == TM_POST_INC |-> tp_q == tbl_addr + 21'h1;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("table pointer not post-incremented"); // RL13

  property p_protect;
    tbl_rd && $past(ctrl_q[CTRL_PROT_BIT]) |-> tbl_addr >= ID_FIRST && tbl_addr <= ID_LAST;
  endproperty
  a_protect: assert property (p_protect) else $error("protected read outside identification words"); // RL16

  property p_bus_one;
    (avm_read || avm_write) && !avm_waitrequest |=> avm_waitrequest;
  endproperty
  a_bus_one: assert property (p_bus_one) else $error("waitrequest low for more than one cycle");

  c_pair: cover property (issue_valid && issue_class == CL_MOVE);
  c_idle: cover property (issue_idle);
  c_table: cover property (tbl_rd && issue_word[1:0] == TM_PRE_INC);
  c_shadow: cover property (shadow_save);

endmodule

// ### pkg/mid_pkg.sv
// Shared constants, types and register map of the instruction decoder/sequencer.
package mid_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 20;
  localparam int OSC_PER_CYCLE = 4;
  localparam int INSTR_CYCLE_NS = OSC_PER_CYCLE * CLK_PERIOD_NS;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);

  // ==========================================================================
  // Instruction encoding constants
  // ==========================================================================
  localparam logic [3:0] SECOND_TAG = 4'hf;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  localparam logic [20:0] ID_FIRST = 21'h200000;
  localparam logic [20:0] ID_LAST = 21'h200004;
  localparam logic [1:0] TM_NONE = 2'h0;
  localparam logic [1:0] TM_POST_INC = 2'h1;
  localparam logic [1:0] TM_POST_DEC = 2'h2;
  localparam logic [1:0] TM_PRE_INC = 2'h3;

  // ==========================================================================
  // Register map (byte addresses) and field positions
  // ==========================================================================
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_BANK = 5'h04;
  localparam logic [4:0] REG_TABLE_PTR = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_COUNT = 5'h10;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_PROT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int ST_STRAY_BIT = 0;
  localparam int ST_BAD2_BIT = 1;
  localparam int ST_BLOCK_BIT = 2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [3:0] {
    CL_NOP, CL_BYTE, CL_BIT, CL_LITERAL, CL_LOAD_PTR, CL_MOVE, CL_REL,
    CL_LONG_XFER, CL_RETURN, CL_TABLE_RD, CL_TABLE_WR, CL_CONTROL
  } mid_class_t;

  typedef enum {SQ_FIRST, SQ_SECOND} mid_seq_t;

  typedef struct packed {
    mid_class_t cls;
    logic two_word;
    logic pc_change;
    logic to_file;
    logic bank_reg;
    logic [7:0] file_addr;
    logic [2:0] bit_num;
    logic [11:0] move_src;
    logic [11:0] move_dst;
    logic [19:0] literal;
    logic [1:0] ptr_sel;
    logic [20:0] target;
    logic target_abs;
    logic shadow_save;
    logic shadow_restore;
    logic [1:0] tbl_mode;
  } mid_fields_t;

  typedef struct packed {
    logic valid;
    logic idle;
    mid_class_t cls;
    logic [15:0] word;
    logic to_file;
    logic access_bank;
    logic [11:0] data_addr;
    logic [2:0] bit_num;
    logic [11:0] move_src;
    logic [11:0] move_dst;
    logic [19:0] literal;
    logic [1:0] ptr_sel;
    logic [20:0] target;
    logic target_abs;
    logic shadow_save;
    logic shadow_restore;
    logic tbl_rd;
    logic tbl_wr;
    logic [20:0] tbl_addr;
  } mid_issue_t;

endpackage

// ### pkg/mid_fld_if.sv
// Carrier between the sequencer and the operand field extractor.
interface mid_fld_if;
  import mid_pkg::*;
  logic [15:0] w0;
  logic [15:0] w1;
  mid_fields_t f;
  modport ext (input w0, input w1, output f);
  modport seq (output w0, output w1, input f);
endinterface

// ### src/mid_fields.sv
// Combinational operand field extraction for one instruction word pair.
module mid_fields
  import mid_pkg::*;
(
  mid_fld_if.ext fx
);

  // ==========================================================================
  // Field extraction
  // ==========================================================================
  // Fields common to byte and bit forms are always extracted; the class says which ones matter.
  always_comb begin
    fx.f = '0;
    fx.f.cls = CL_BYTE;
    fx.f.file_addr = fx.w0[7:0]; // RL10
    fx.f.to_file = fx.w0[9]; // RL7
    fx.f.bank_reg = fx.w0[8]; // RL8
    fx.f.tbl_mode = fx.w0[1:0]; // RL13
    priority casez (fx.w0)
      16'b1111_????_????_???? : fx.f.cls = CL_NOP; // RL3
      16'b1100_????_????_???? : begin
        fx.f.cls = CL_MOVE;
        fx.f.two_word = 1'b1; // RL1
        fx.f.move_src = fx.w0[11:0]; // RL11
        fx.f.move_dst = fx.w1[11:0]; // RL11
      end
      16'b1101_????_????_???? : begin
        fx.f.cls = CL_REL;
        fx.f.pc_change = 1'b1;
        fx.f.target = {{10{fx.w0[10]}}, fx.w0[10:0]}; // RL14
      end
      16'b1110_0???_????_???? : begin
        fx.f.cls = CL_REL;
        fx.f.target = {{13{fx.w0[7]}}, fx.w0[7:0]}; // RL14
      end
      16'b1110_110?_????_????,
      16'b1110_1111_????_???? : begin
        fx.f.cls = CL_LONG_XFER;
        fx.f.two_word = 1'b1; // RL1
        fx.f.pc_change = 1'b1;
        fx.f.literal = {fx.w1[11:0], fx.w0[7:0]}; // RL12
        fx.f.target = {1'b0, fx.w1[11:0], fx.w0[7:0]}; // RL14
        fx.f.target_abs = 1'b1;
        // Only the call form carries the fast bit; the absolute branch never saves.
        fx.f.shadow_save = (fx.w0[9] == 1'b0) && fx.w0[8]; // RL18
      end
      16'b1110_1110_00??_???? : begin
        fx.f.cls = CL_LOAD_PTR;
        fx.f.two_word = 1'b1; // RL1
        fx.f.ptr_sel = fx.w0[5:4]; // RL15
        fx.f.literal = {8'h00, fx.w0[3:0], fx.w1[7:0]}; // RL12
      end
      16'b1110_????_????_???? : fx.f.cls = CL_CONTROL;
      16'b0111_????_????_????,
      16'b10??_????_????_???? : begin
        fx.f.cls = CL_BIT;
        fx.f.bit_num = fx.w0[11:9]; // RL9
      end
      16'b0000_1???_????_???? : begin
        fx.f.cls = CL_LITERAL;
        fx.f.literal = {12'h000, fx.w0[7:0]}; // RL12
      end
      16'b0000_0000_0000_10?? : fx.f.cls = CL_TABLE_RD;
      16'b0000_0000_0000_11?? : fx.f.cls = CL_TABLE_WR;
      16'b0000_0000_0001_00?? : begin
        fx.f.cls = CL_RETURN;
        fx.f.pc_change = 1'b1;
        fx.f.target_abs = 1'b1; // RL14
        fx.f.shadow_restore = fx.w0[0]; // RL18
      end
      16'b0000_0000_????_???? : fx.f.cls = CL_CONTROL;
      default : fx.f.cls = CL_BYTE;
    endcase
  end

endmodule

// ### sim/mid_prog_mem.sv
// Program memory model that feeds instruction words to the decoder.
module mid_prog_mem (
  input wire logic ref_clk,
  input wire logic restart,
  input wire logic stall,
  input wire logic prog_taken,
  output logic [15:0] prog_word,
  output logic prog_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [64];
  int len = 0;
  int ptr = 0;
  logic [15:0] last = 16'h0000;
  // ==========================================================================
  // Word supply
  // ==========================================================================
  // An unoffered word shows the inverse of the last one, so stale data never passes.
  assign prog_valid = (ptr < len) && !stall;
  assign prog_word = prog_valid ? mem[ptr] : ~last;
  // The pointer moves on when the decoder reports a word consumed.
  always @(posedge ref_clk) begin
    if (restart) begin
      ptr <= 0;
    end else if (prog_taken === 1'b1) begin
      last <= mem[ptr];
      ptr <= ptr + 1;
    end
  end
endmodule

// ### sim/mid_decoder_test.sv
// Self-checking testbench of the instruction decoder and sequencer.
module mid_decoder_test;
  import mid_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic idle; logic [3:0] cls; logic [31:0] key; int gap;} mid_exp_t;
  logic ref_clk = 0, resetn = 0, clk_en = 1, cond_true = 0, restart = 0, stall = 0, rnd = 0;
  logic [15:0] prog_word, issue_word;
  logic prog_valid, prog_taken, avm_waitrequest, issue_valid, issue_idle, result_to_file, access_bank;
  logic target_abs, shadow_save, shadow_restore, tbl_rd, tbl_wr;
  logic [4:0] avm_address = 5'h00;
  logic avm_read = 0, avm_write = 0;
  logic [3:0] avm_byteenable = 4'hf, issue_class, b;
  logic [31:0] avm_writedata = 32'h0, avm_readdata, rd, kk;
  logic [11:0] data_addr, move_src, move_dst, s, d;
  logic [2:0] bit_num;
  logic [19:0] literal, k;
  logic [1:0] ptr_sel;
  logic [20:0] prog_target, tbl_addr;
  logic [7:0] f;
  int failures = 0, tests_run = 0, cyc = 0, last_ev = 0, i;
  mid_exp_t q[$];
  mid_exp_t e;
  mid_decoder i_dut (.*);
  mid_prog_mem i_mem (.ref_clk, .restart, .stall, .prog_taken, .prog_word, .prog_valid);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // One bus access; the request is held until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] dt, output logic [31:0] r);
    @(posedge ref_clk);
    avm_address <= a;
    avm_write <= wr;
    avm_read <= !wr;
    avm_writedata <= dt;
    do begin
      @(posedge ref_clk);
    end while (avm_waitrequest !== 1'b0);
    r = avm_readdata;
    avm_read <= 0;
    avm_write <= 0;
  endtask
  task automatic ex(input logic [3:0] c, input logic [31:0] kv, input int g);
    q.push_back('{1'b0, c, kv, g});
  endtask
  task automatic idle();
    q.push_back('{1'b1, 4'h0, 32'h0, 4});
  endtask
  task automatic w(input logic [15:0] x);
    i_mem.mem[i_mem.len] = x;
    i_mem.len++;
  endtask
  task automatic start();
    restart <= 1;
    @(posedge ref_clk);
    restart <= 0;
    i_mem.len = 0;
  endtask
  task automatic go(input string name);
    // Only the watchdog ends a wait, so a hang cannot slip through to the verdict.
    while (q.size() > 0) begin
      @(posedge ref_clk);
    end
    repeat (12) @(posedge ref_clk);
    $display("test %s done", name);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================================
  // Monitor
  // ==========================================================================
  // Each issued or idle cycle takes the oldest note; spacing is checked in clocks.
  always @(posedge ref_clk) begin
    cyc++;
    if (issue_valid === 1'b1 || issue_idle === 1'b1) begin
      // An event with nothing noted meets a class that never occurs, so it counts as a mismatch.
      if (q.size() > 0) e = q.pop_front();
      else e = '{1'b1, 4'hf, 32'h0, 0};
      case (issue_class)
        CL_BYTE: kk = {result_to_file, access_bank, data_addr};
        CL_BIT: kk = {bit_num, access_bank, data_addr};
        CL_MOVE: kk = {move_src, move_dst};
        CL_LITERAL: kk = literal;
        CL_LOAD_PTR: kk = {ptr_sel, literal};
        CL_REL, CL_LONG_XFER: kk = {shadow_save, shadow_restore, target_abs, prog_target};
        CL_RETURN: kk = {issue_word, shadow_restore, target_abs};
        CL_TABLE_RD, CL_TABLE_WR: kk = {tbl_wr, tbl_rd, tbl_addr};
        default: kk = issue_word;
      endcase
      chk({issue_idle, issue_class}, {e.idle, e.cls});
      chk(kk, e.key);
      if (e.gap != 0) chk(cyc - last_ev, e.gap);
      last_ev = cyc;
    end
  end
  always @(posedge ref_clk) stall <= rnd & 1'($urandom);
  initial begin
    #400000;
    failures++;
    conclude();
  end
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    void'($urandom(32'h194c0834));
    repeat (4) @(posedge ref_clk);
    resetn <= 1;
    bus(0, REG_CTRL, 0, rd);
    chk(rd, 32'h1);
    bus(0, 5'h14, 0, rd);
    chk(rd, 32'h0);
    b = 4'($urandom);
    bus(1, REG_BANK, 32'(b), rd);
    start();
    for (i = 0; i < 12; i++) begin
      f = 8'($urandom);
      if (i < 4) w({6'h09, i[1:0], f});
      if (i < 4) ex(CL_BYTE, {i[1], ~i[0], i[0] ? b : 4'h0, f}, i ? 4 : 0);
      if (i >= 4) w({4'h8, i[2:0], i[0], f});
      if (i >= 4) ex(CL_BIT, {i[2:0], ~i[0], i[0] ? b : 4'h0, f}, 4);
    end
    go("byte_bit");
    start();
    s = 12'($urandom);
    d = 12'($urandom);
    k = 20'($urandom);
    w({4'hc, s});
    w({4'hf, d});
    ex(CL_MOVE, {s, d}, 0);
    w({8'hef, k[7:0]});
    w({4'hf, k[19:8]});
    ex(CL_LONG_XFER, {3'b001, 1'b0, k}, 8);
    idle();
    w({8'hed, k[7:0]});
    w({4'hf, k[19:8]});
    ex(CL_LONG_XFER, {3'b101, 1'b0, k}, 8);
    idle();
    w({8'hee, 2'b00, k[13:12], k[11:8]});
    w({8'hf0, k[7:0]});
    ex(CL_LOAD_PTR, {k[13:12], 8'h00, k[11:0]}, 8);
    w({8'h0e, k[7:0]});
    ex(CL_LITERAL, k[7:0], 4);
    w({5'h1a, k[10:0]});
    ex(CL_REL, {3'b000, {10{k[10]}}, k[10:0]}, 4);
    idle();
    w({4'hf, d});
    ex(CL_NOP, {4'hf, d}, 4);
    w(16'h0013);
    ex(CL_RETURN, {16'h0013, 2'b11}, 4);
    idle();
    go("pairs");
    bus(1, REG_TABLE_PTR, 32'(ID_FIRST), rd);
    bus(1, REG_CTRL, 32'h3, rd);
    start();
    for (i = 0; i < 5; i++) begin
      w(16'h0008 | 16'(i));
      ex(i < 4 ? CL_TABLE_RD : CL_TABLE_WR, {i == 4, i < 4, ID_FIRST + 21'(i > 1)}, i ? 4 : 0);
    end
    go("table");
    bus(0, REG_TABLE_PTR, 0, rd);
    chk(rd, 32'(ID_FIRST) + 1);
    cond_true <= 1;
    start();
    for (i = 0; i < 3; i++) begin
      w({4'hb, i[2:0], 1'b0, f});
      ex(CL_BIT, {i[2:0], 1'b1, 4'h0, f}, i ? 4 : 0);
      idle();
    end
    go("cond");
    cond_true <= 0;
    rnd <= 1;
    start();
    for (i = 0; i < 6; i++) begin
      k = 20'($urandom);
      w({8'h0e, k[7:0]});
      ex(CL_LITERAL, k[7:0], 0);
    end
    go("stall");
    rnd <= 0;
    bus(0, REG_STATUS, 0, rd);
    chk(rd & 32'h1, 32'h1);
    conclude();
  end
endmodule
